/* File: design/ieamu_core.v */
// integer datapath: banked register file, alu, address adder, multiply/divide unit
// assumes all inputs synchronous to clk; issuer honours div_busy_q before md issue
//
// Overview of operation
// RULE1: logical, shift, add and subtract results are registered one cycle after issue.
// RULE2: thirty-two general registers of 32 bits each for data and addresses.
// RULE3: seven further complete sets of thirty-two registers, selected per access.
// RULE4: two read ports, one write port, same-cycle write bypassed into reads.
// RULE5: separate 32-bit adder forms load/store data addresses.
// RULE6: leading zero and leading one counter for count instructions.
// RULE7: multiply/divide pipeline has no stall input and always advances.
// RULE8: radix-4 booth multiplier, first operand rs, second operand rt.
// RULE9: four high/low accumulator pairs hold multiply and divide results.
// RULE10: multiplier accepts a new multiply or accumulate every clock.
// RULE11: every multiply form has five cycle latency and one cycle repeat.
// RULE12: divider resolves one quotient bit per clock.
// RULE13: dividend sign extension check skips 23, 15 or 7 iterations.
// RULE14: divide takes 12/14, 20/22, 28/30 or 36/38 clocks, unsigned/signed.
// RULE15: further multiply/divide issue during a divide stalls the integer pipeline.
// RULE16: wide dividends run every iteration, completion only after the last one.
`timescale 1ns/10ps
`include "ieamu_map.vh"

module ieamu_core #(
	parameter NSETS = 8,
	parameter MUL_LAT = `IEAMU_MUL_LAT
) (
	// clock and reset
	input wire clk,
	input wire reset,
	// register file access
	input wire [2:0] rf_set,
	input wire [4:0] rs_addr,
	input wire [4:0] rt_addr,
	input wire rf_we,
	input wire [2:0] rf_wset,
	input wire [4:0] rf_waddr,
	input wire [31:0] rf_wdata,
	// alu and address adder issue
	input wire alu_valid,
	input wire [3:0] alu_op,
	input wire agu_valid,
	input wire [15:0] agu_offset,
	// multiply/divide issue and accumulator read
	input wire md_valid,
	input wire [3:0] md_op,
	input wire [1:0] md_acc,
	input wire [4:0] md_rd,
	input wire [1:0] hl_acc,
	// results
	output reg alu_valid_q,
	output reg [31:0] alu_result_q,
	output reg agu_valid_q,
	output reg [31:0] agu_addr_q,
	output reg md_wb_valid_q,
	output reg [4:0] md_wb_rd_q,
	output reg [31:0] md_wb_data_q,
	output reg [31:0] hl_hi_q,
	output reg [31:0] hl_lo_q,
	output reg div_busy_q,
	output reg div_done_q
);

	// ---------------------------------------------------------------
	// register file
	// ---------------------------------------------------------------
	// data storage only, so no reset; register zero of every set reads zero
	reg [31:0] rf_mem [0:NSETS*32-1]; // see RULE2 see RULE3
	wire [7:0] rs_idx = {rf_set, rs_addr};
	wire [7:0] rt_idx = {rf_set, rt_addr};
	wire [7:0] w_idx = {rf_wset, rf_waddr};
	reg [31:0] rs_val;
	reg [31:0] rt_val;

	always @(posedge clk) begin
		if (rf_we && rf_waddr != 5'h00)
			rf_mem[w_idx] <= rf_wdata; // see RULE4
	end

	always @* begin
		rs_val = 32'h0000_0000;
		rt_val = 32'h0000_0000;
		if (rs_addr != 5'h00) begin
			if (rf_we && w_idx == rs_idx)
				rs_val = rf_wdata; // see RULE4
			else
				rs_val = rf_mem[rs_idx];
		end
		if (rt_addr != 5'h00) begin
			if (rf_we && w_idx == rt_idx)
				rt_val = rf_wdata; // see RULE4
			else
				rt_val = rf_mem[rt_idx];
		end
	end

	// ---------------------------------------------------------------
	// alu, count and address adder
	// ---------------------------------------------------------------
	function [5:0] lead_count;
		input [31:0] v;
		input ones;
		integer i;
		reg run;
		begin
			lead_count = 6'h00;
			run = 1'b1;
			for (i = 31; i >= 0; i = i - 1) begin
				if (run && (v[i] == ones))
					lead_count = lead_count + 6'h01;
				else
					run = 1'b0;
			end
		end
	endfunction

	reg [31:0] alu_d;
	wire [32:0] diff = {1'b0, rs_val} - {1'b0, rt_val};

	always @* begin
		alu_d = 32'h0000_0000;
		case (alu_op)
			`IEAMU_ALU_AND: alu_d = rs_val & rt_val;
			`IEAMU_ALU_OR: alu_d = rs_val | rt_val;
			`IEAMU_ALU_XOR: alu_d = rs_val ^ rt_val;
			`IEAMU_ALU_NOR: alu_d = ~(rs_val | rt_val);
			`IEAMU_ALU_ADD: alu_d = rs_val + rt_val;
			`IEAMU_ALU_SUB: alu_d = diff[31:0];
			`IEAMU_ALU_SLL: alu_d = rs_val << rt_val[4:0];
			`IEAMU_ALU_SRL: alu_d = rs_val >> rt_val[4:0];
			`IEAMU_ALU_SRA: alu_d = $signed(rs_val) >>> rt_val[4:0];
			`IEAMU_ALU_SLT: alu_d = {31'h0, $signed(rs_val) < $signed(rt_val)};
			`IEAMU_ALU_SLTU: alu_d = {31'h0, diff[32]};
			`IEAMU_ALU_CLZ: alu_d = {26'h0, lead_count(rs_val, 1'b0)}; // see RULE6
			`IEAMU_ALU_CLO: alu_d = {26'h0, lead_count(rs_val, 1'b1)}; // see RULE6
			default: alu_d = 32'h0000_0000;
		endcase
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			alu_valid_q <= 1'b0;
			alu_result_q <= 32'h0000_0000;
			agu_valid_q <= 1'b0;
			agu_addr_q <= 32'h0000_0000;
		end else begin
			alu_valid_q <= alu_valid;
			if (alu_valid)
				alu_result_q <= alu_d; // see RULE1
			agu_valid_q <= agu_valid;
			if (agu_valid)
				agu_addr_q <= rs_val + {{16{agu_offset[15]}}, agu_offset}; // see RULE5
		end
	end

	// ---------------------------------------------------------------
	// multiplier pipeline
	// ---------------------------------------------------------------
	function [65:0] booth_mul;
		input [32:0] a;
		input [32:0] b;
		integer i;
		reg [35:0] bx;
		reg [65:0] ax;
		reg [65:0] pp;
		begin
			booth_mul = 66'h0;
			bx = {b[32], b[32], b, 1'b0};
			ax = {{33{a[32]}}, a};
			for (i = 0; i < 17; i = i + 1) begin
				case (bx[2*i +: 3])
					3'h1, 3'h2: pp = ax;
					3'h3: pp = ax << 1;
					3'h4: pp = -(ax << 1);
					3'h5, 3'h6: pp = -ax;
					default: pp = 66'h0;
				endcase
				booth_mul = booth_mul + (pp << (2 * i));
			end
		end
	endfunction

	// signed forms: mult, madd, msub, mul and div
	wire md_signed = (md_op == `IEAMU_MD_MULT) || (md_op == `IEAMU_MD_MADD) ||
		(md_op == `IEAMU_MD_MSUB) || (md_op == `IEAMU_MD_MUL) || (md_op == `IEAMU_MD_DIV);
	wire md_is_div = (md_op == `IEAMU_MD_DIV) || (md_op == `IEAMU_MD_DIVU);
	// refused while a divide runs; the issuer stalls on div_busy_q
	wire md_take = md_valid && !div_busy_q; // see RULE15
	wire mul_take = md_take && !md_is_div; // see RULE10
	wire [65:0] prod_full = booth_mul({md_signed & rs_val[31], rs_val},
		{md_signed & rt_val[31], rt_val}); // see RULE8

	reg [MUL_LAT-2:0] st_v_q;
	reg [63:0] st_p_q [0:MUL_LAT-2];
	reg [3:0] st_op_q [0:MUL_LAT-2];
	reg [1:0] st_acc_q [0:MUL_LAT-2];
	reg [4:0] st_rd_q [0:MUL_LAT-2];

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			st_v_q[0] <= 1'b0;
			st_p_q[0] <= 64'h0;
			st_op_q[0] <= 4'h0;
			st_acc_q[0] <= 2'h0;
			st_rd_q[0] <= 5'h00;
		end else begin
			st_v_q[0] <= mul_take;
			st_p_q[0] <= prod_full[63:0];
			st_op_q[0] <= md_op;
			st_acc_q[0] <= md_acc;
			st_rd_q[0] <= md_rd;
		end
	end

	// no stall term anywhere in these stages
	genvar g;
	generate
		for (g = 1; g < MUL_LAT - 1; g = g + 1) begin : g_mstage
			always @(posedge clk or posedge reset) begin
				if (reset) begin
					st_v_q[g] <= 1'b0;
					st_p_q[g] <= 64'h0;
					st_op_q[g] <= 4'h0;
					st_acc_q[g] <= 2'h0;
					st_rd_q[g] <= 5'h00;
				end else begin
					st_v_q[g] <= st_v_q[g-1]; // see RULE7 see RULE11
					st_p_q[g] <= st_p_q[g-1];
					st_op_q[g] <= st_op_q[g-1];
					st_acc_q[g] <= st_acc_q[g-1];
					st_rd_q[g] <= st_rd_q[g-1];
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// divider state
	// ---------------------------------------------------------------
	reg [31:0] acc_hi_q [0:3]; // see RULE9
	reg [31:0] acc_lo_q [0:3];
	reg [5:0] div_cnt_q;
	reg [5:0] div_iter_q;
	reg [5:0] div_lat_q;
	reg [32:0] div_rem_q;
	reg [31:0] div_quo_q;
	reg [31:0] div_dvs_q;
	reg div_qneg_q;
	reg div_rneg_q;
	reg [1:0] div_acc_q;

	wire [31:0] dvd_mag = (md_signed && rs_val[31]) ? (~rs_val + 32'h1) : rs_val;
	wire [31:0] dvs_mag = (md_signed && rt_val[31]) ? (~rt_val + 32'h1) : rt_val;
	wire fit8 = md_signed ? (rs_val[31:7] == {25{rs_val[31]}}) : (rs_val[31:8] == 24'h0);
	wire fit16 = md_signed ? (rs_val[31:15] == {17{rs_val[31]}}) : (rs_val[31:16] == 16'h0);
	wire fit24 = md_signed ? (rs_val[31:23] == {9{rs_val[31]}}) : (rs_val[31:24] == 8'h0);
	reg [5:0] skip_d;
	reg [5:0] lat_d;

	always @* begin
		if (fit8) begin
			skip_d = `IEAMU_SKIP8; // see RULE13
			lat_d = md_signed ? `IEAMU_DLAT8_S : `IEAMU_DLAT8_U; // see RULE14
		end else if (fit16) begin
			skip_d = `IEAMU_SKIP16;
			lat_d = md_signed ? `IEAMU_DLAT16_S : `IEAMU_DLAT16_U;
		end else if (fit24) begin
			skip_d = `IEAMU_SKIP24;
			lat_d = md_signed ? `IEAMU_DLAT24_S : `IEAMU_DLAT24_U;
		end else begin
			skip_d = 6'h00; // see RULE16
			lat_d = md_signed ? `IEAMU_DLAT32_S : `IEAMU_DLAT32_U;
		end
	end

	wire [32:0] trial = {div_rem_q[31:0], div_quo_q[31]} - {1'b0, div_dvs_q};
	wire div_step = div_busy_q && (div_cnt_q < div_iter_q);
	wire div_end = div_busy_q && (div_cnt_q == div_lat_q - 6'h01);
	wire [31:0] q_fix = div_qneg_q ? (~div_quo_q + 32'h1) : div_quo_q;
	wire [31:0] r_fix = div_rneg_q ? (~div_rem_q[31:0] + 32'h1) : div_rem_q[31:0];

	// ---------------------------------------------------------------
	// final multiply stage, accumulators and divide sequencing
	// ---------------------------------------------------------------
	localparam LAST = MUL_LAT - 2;
	wire [3:0] l_op = st_op_q[LAST];
	wire [1:0] l_acc = st_acc_q[LAST];
	wire [63:0] l_old = {acc_hi_q[l_acc], acc_lo_q[l_acc]};
	wire [63:0] l_sum = ((l_op == `IEAMU_MD_MADD) || (l_op == `IEAMU_MD_MADDU)) ?
		l_old + st_p_q[LAST] : (((l_op == `IEAMU_MD_MSUB) || (l_op == `IEAMU_MD_MSUBU)) ?
		l_old - st_p_q[LAST] : st_p_q[LAST]);
	integer k;

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			for (k = 0; k < 4; k = k + 1) begin
				acc_hi_q[k] <= 32'h0000_0000;
				acc_lo_q[k] <= 32'h0000_0000;
			end
			md_wb_valid_q <= 1'b0;
			md_wb_rd_q <= 5'h00;
			md_wb_data_q <= 32'h0000_0000;
			hl_hi_q <= 32'h0000_0000;
			hl_lo_q <= 32'h0000_0000;
			div_busy_q <= 1'b0;
			div_done_q <= 1'b0;
			div_cnt_q <= 6'h00;
			div_iter_q <= 6'h00;
			div_lat_q <= 6'h00;
			div_rem_q <= 33'h0;
			div_quo_q <= 32'h0000_0000;
			div_dvs_q <= 32'h0000_0000;
			div_qneg_q <= 1'b0;
			div_rneg_q <= 1'b0;
			div_acc_q <= 2'h0;
		end else begin
			hl_hi_q <= acc_hi_q[hl_acc];
			hl_lo_q <= acc_lo_q[hl_acc];
			md_wb_valid_q <= st_v_q[LAST] && (l_op == `IEAMU_MD_MUL); // see RULE11
			md_wb_rd_q <= st_rd_q[LAST];
			md_wb_data_q <= st_p_q[LAST][31:0];
			// mul writes only the general register, the other forms the pair
			if (st_v_q[LAST] && l_op != `IEAMU_MD_MUL) begin
				acc_hi_q[l_acc] <= l_sum[63:32];
				acc_lo_q[l_acc] <= l_sum[31:0];
			end
			div_done_q <= div_end;
			if (md_take && md_is_div) begin
				div_busy_q <= 1'b1;
				div_cnt_q <= 6'h00;
				div_iter_q <= `IEAMU_DIV_BITS - skip_d;
				div_lat_q <= lat_d;
				div_rem_q <= 33'h0;
				div_quo_q <= dvd_mag << skip_d;
				div_dvs_q <= dvs_mag;
				div_qneg_q <= md_signed && (rs_val[31] ^ rt_val[31]);
				div_rneg_q <= md_signed && rs_val[31];
				div_acc_q <= md_acc;
			end else if (div_busy_q) begin
				div_cnt_q <= div_cnt_q + 6'h01;
				if (div_step) begin
					div_rem_q <= trial[32] ? {div_rem_q[31:0], div_quo_q[31]} : trial; // see RULE12
					div_quo_q <= {div_quo_q[30:0], ~trial[32]};
				end
				if (div_end) begin
					div_busy_q <= 1'b0; // see RULE15
					acc_hi_q[div_acc_q] <= r_fix;
					acc_lo_q[div_acc_q] <= q_fix;
				end
			end
		end
	end

endmodule // ieamu_core

/* File: design/ieamu_map.vh */
// constants for the integer execution and multiply/divide unit
// assumes inclusion by ieamu_core.v, the checker and the bench; definitions only
`ifndef IEAMU_MAP_VH
`define IEAMU_MAP_VH

// ---------------------------------------------------------------
// alu operation codes
// ---------------------------------------------------------------
`define IEAMU_ALU_AND 4'h0
`define IEAMU_ALU_OR 4'h1
`define IEAMU_ALU_XOR 4'h2
`define IEAMU_ALU_NOR 4'h3
`define IEAMU_ALU_ADD 4'h4
`define IEAMU_ALU_SUB 4'h5
`define IEAMU_ALU_SLL 4'h6
`define IEAMU_ALU_SRL 4'h7
`define IEAMU_ALU_SRA 4'h8
`define IEAMU_ALU_SLT 4'h9
`define IEAMU_ALU_SLTU 4'ha
`define IEAMU_ALU_CLZ 4'hb
`define IEAMU_ALU_CLO 4'hc

// ---------------------------------------------------------------
// multiply/divide operation codes
// ---------------------------------------------------------------
`define IEAMU_MD_MULT 4'h0
`define IEAMU_MD_MULTU 4'h1
`define IEAMU_MD_MADD 4'h2
`define IEAMU_MD_MADDU 4'h3
`define IEAMU_MD_MSUB 4'h4
`define IEAMU_MD_MSUBU 4'h5
`define IEAMU_MD_MUL 4'h6
`define IEAMU_MD_DIV 4'h7
`define IEAMU_MD_DIVU 4'h8

// ---------------------------------------------------------------
// timing figures, in pipeline clocks
// ---------------------------------------------------------------
`define IEAMU_MUL_LAT 5
`define IEAMU_DIV_BITS 6'h20
`define IEAMU_SKIP8 6'h17
`define IEAMU_SKIP16 6'h0f
`define IEAMU_SKIP24 6'h07
`define IEAMU_DLAT8_U 6'h0c
`define IEAMU_DLAT8_S 6'h0e
`define IEAMU_DLAT16_U 6'h14
`define IEAMU_DLAT16_S 6'h16
`define IEAMU_DLAT24_U 6'h1c
`define IEAMU_DLAT24_S 6'h1e
`define IEAMU_DLAT32_U 6'h24
`define IEAMU_DLAT32_S 6'h26

`endif

/* File: verification/ieamu_chk.sv */
// checker: issue-to-result timing of ieamu_core
// assumes binding onto ieamu_core; one clock, async reset
`timescale 1ns/10ps
`include "ieamu_map.vh"
module ieamu_chk (
	// clock and reset
	input wire clk,
	input wire reset,
	// issue and result ports
	input wire alu_valid,
	input wire alu_valid_q,
	input wire agu_valid,
	input wire agu_valid_q,
	input wire md_valid,
	input wire [3:0] md_op,
	input wire md_wb_valid_q,
	input wire div_busy_q,
	input wire div_done_q
);
	wire mul_go = md_valid && md_op == `IEAMU_MD_MUL && !div_busy_q;
	wire div_op = md_op == `IEAMU_MD_DIV || md_op == `IEAMU_MD_DIVU;
	wire div_go = md_valid && !div_busy_q && div_op;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// ----------
	// assertions
	// ----------
	a_alu_one_cycle: assert property (alu_valid |=> alu_valid_q)
		else $error("alu result not one cycle after issue");
	a_agu_one_cycle: assert property (agu_valid |=> agu_valid_q)
		else $error("address not one cycle after issue");
	a_mul_five: assert property (mul_go |-> ##5 md_wb_valid_q)
		else $error("mul result not five cycles after issue");
	a_mul_no_spur: assert property (md_wb_valid_q |-> $past(mul_go, 5))
		else $error("mul result without accepted issue");
	a_div_starts: assert property (div_go |=> div_busy_q)
		else $error("divide did not start");
	a_div_min_busy: assert property ($rose(div_busy_q) |-> div_busy_q [*8])
		else $error("divide ended too early");
	a_div_bound: assert property ($rose(div_busy_q) |-> ##[12:38] div_done_q)
		else $error("divide did not end in time");
	a_done_ends: assert property (div_done_q |-> !div_busy_q && $past(div_busy_q))
		else $error("done without end of busy");
	c_mul: cover property (mul_go);
	c_div: cover property (div_done_q);
	c_both: cover property (alu_valid && agu_valid);
endmodule // ieamu_chk

bind ieamu_core ieamu_chk u_chk (.clk(clk), .reset(reset), .alu_valid(alu_valid),
	.alu_valid_q(alu_valid_q), .agu_valid(agu_valid), .agu_valid_q(agu_valid_q),
	.md_valid(md_valid), .md_op(md_op), .md_wb_valid_q(md_wb_valid_q),
	.div_busy_q(div_busy_q), .div_done_q(div_done_q));

/* File: verification/ieamu_issuer.sv */
// issue pipeline model in front of the multiply/divide port
// assumes requests come from the bench, busy from the core
`timescale 1ns/10ps
module ieamu_issuer (
	// bench side
	input wire req,
	input wire rude,
	// core side
	input wire div_busy_q,
	output wire md_valid,
	output wire stall
);
	// rude lets a scenario push into a running divide on purpose
	assign md_valid = req && (!div_busy_q || rude);
	assign stall = req && div_busy_q;
endmodule // ieamu_issuer

/* File: verification/tb.sv */
// self-checking bench for ieamu_core
// assumes ieamu_issuer as issue pipeline, ieamu_chk bound on the core
`timescale 1ns/10ps
`include "ieamu_map.vh"
`define CHK(nm, e, g) begin n_checks++; if ((e) !== (g)) begin errors++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb;
	reg clk = 0, reset = 1, rf_we = 0, alu_valid = 0, agu_valid = 0, req = 0, rude = 0;
	reg [2:0] rf_set = 0, rf_wset = 0;
	reg [4:0] rs_addr = 0, rt_addr = 0, rf_waddr = 0, md_rd = 0;
	reg [31:0] rf_wdata = 0;
	reg [3:0] alu_op = 0, md_op = 0;
	reg [15:0] agu_offset = 0;
	reg [1:0] md_acc = 0, hl_acc = 0;
	wire md_valid, alu_valid_q, agu_valid_q, md_wb_valid_q, div_busy_q, div_done_q;
	wire [4:0] md_wb_rd_q;
	wire [31:0] alu_result_q, agu_addr_q, md_wb_data_q, hl_hi_q, hl_lo_q;
	reg [31:0] rf [0:31];
	reg [31:0] dv [0:7];
	int lt [0:7];
	reg [31:0] qa[$], qg[$];
	reg [36:0] qm[$];
	reg [63:0] qd[$];
	reg [63:0] e64;
	int qt[$];
	int errors = 0, n_checks = 0, cyc = 0, i, a;
	reg dchk = 0;
	always #5 clk = ~clk;
	ieamu_core DUT (.clk(clk), .reset(reset), .rf_set(rf_set), .rs_addr(rs_addr),
		.rt_addr(rt_addr), .rf_we(rf_we), .rf_wset(rf_wset), .rf_waddr(rf_waddr),
		.rf_wdata(rf_wdata), .alu_valid(alu_valid), .alu_op(alu_op), .agu_valid(agu_valid),
		.agu_offset(agu_offset), .md_valid(md_valid), .md_op(md_op), .md_acc(md_acc),
		.md_rd(md_rd), .hl_acc(hl_acc), .alu_valid_q(alu_valid_q), .alu_result_q(alu_result_q),
		.agu_valid_q(agu_valid_q), .agu_addr_q(agu_addr_q), .md_wb_valid_q(md_wb_valid_q),
		.md_wb_rd_q(md_wb_rd_q), .md_wb_data_q(md_wb_data_q), .hl_hi_q(hl_hi_q),
		.hl_lo_q(hl_lo_q), .div_busy_q(div_busy_q), .div_done_q(div_done_q));
	ieamu_issuer u_iss (.req(req), .rude(rude), .div_busy_q(div_busy_q),
		.md_valid(md_valid), .stall());
	task end_sim;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// hang guard, far above the few hundred cycles needed
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			errors++;
			end_sim;
		end
	end
	// ---------------------------
	// result monitor
	// ---------------------------
	always @(negedge clk) begin
		if (alu_valid_q === 1'b1)
			`CHK("alu", qa.pop_front(), alu_result_q)
		if (agu_valid_q === 1'b1)
			`CHK("agu", qg.pop_front(), agu_addr_q)
		if (md_wb_valid_q === 1'b1)
			`CHK("mul", qm.size() ? qm.pop_front() : 'x, {md_wb_rd_q, md_wb_data_q})
		if (dchk)
			`CHK("div", qd.pop_front(), {hl_hi_q, hl_lo_q})
		dchk = div_done_q === 1'b1;
		if (dchk)
			`CHK("div time", qt.pop_front(), cyc)
	end
	function [31:0] lead(input [31:0] v, input o);
		integer k;
		lead = 32;
		for (k = 0; k < 32; k++)
			if (v[k] != o)
				lead = 31 - k;
	endfunction
	function [31:0] alu_ref(input [3:0] op, input [31:0] x, input [31:0] y);
		case (op)
			`IEAMU_ALU_AND: alu_ref = x & y;
			`IEAMU_ALU_OR: alu_ref = x | y;
			`IEAMU_ALU_XOR: alu_ref = x ^ y;
			`IEAMU_ALU_NOR: alu_ref = ~(x | y);
			`IEAMU_ALU_ADD: alu_ref = x + y;
			`IEAMU_ALU_SUB: alu_ref = x - y;
			`IEAMU_ALU_SLL: alu_ref = x << y[4:0];
			`IEAMU_ALU_SRL: alu_ref = x >> y[4:0];
			`IEAMU_ALU_SRA: alu_ref = $signed(x) >>> y[4:0];
			`IEAMU_ALU_SLT: alu_ref = {31'h0, $signed(x) < $signed(y)};
			`IEAMU_ALU_SLTU: alu_ref = {31'h0, x < y};
			default: alu_ref = lead(x, op == `IEAMU_ALU_CLO);
		endcase
	endfunction
	// write strobe stays up between writes; caller drops it
	task wr(input [2:0] s, input [4:0] ad, input [31:0] d);
		rf_we = 1;
		rf_wset = s;
		rf_waddr = ad;
		rf_wdata = d;
		if (s == 0 && ad != 0)
			rf[ad] = d;
		@(negedge clk);
	endtask
	task alu(input [3:0] op, input [4:0] s, input [4:0] t, input [31:0] x, input [31:0] y);
		alu_valid = 1;
		agu_valid = 1;
		alu_op = op;
		rs_addr = s;
		rt_addr = t;
		agu_offset = $urandom;
		qa.push_back(alu_ref(op, x, y));
		qg.push_back(x + {{16{agu_offset[15]}}, agu_offset});
		@(negedge clk);
	endtask
	// request held until the edge that takes it; caller drops req
	task md(input [3:0] op, input [1:0] ac, input [4:0] s, input [4:0] t, input int lat,
		input [63:0] e);
		req = 1;
		md_op = op;
		md_acc = ac;
		md_rd = s ^ t;
		rs_addr = s;
		rt_addr = t;
		while (div_busy_q === 1'b1)
			@(negedge clk);
		if (op == `IEAMU_MD_MUL)
			qm.push_back({md_rd, e[31:0]});
		if (lat > 0) begin
			qt.push_back(cyc + 1 + lat);
			qd.push_back(e);
		end
		@(negedge clk);
	endtask
	initial begin
		i = $urandom(32'h48754106);
		dv = '{32'hff, 32'h100, 32'h123456, 32'h92345678,
			32'hffffff80, 32'hffff8000, 32'h00800000, 32'hff800000};
		lt = '{12, 20, 28, 36, 14, 22, 38, 30};
		rf[0] = 0;
		repeat (8) @(negedge clk);
		reset = 0;
		hl_acc = 3;
		@(negedge clk);
		`CHK("acc reset", 64'h0, {hl_hi_q, hl_lo_q})
		wr(7, 1, 32'h5a5a0f0f);
		for (i = 1; i < 11; i++)
			wr(0, 5'(i), $urandom);
		wr(0, 10, 32'h7);
		wr(0, 12, 32'hfff00000);
		wr(0, 0, 32'h1);
		rf_we = 0;
		for (i = 0; i < 13; i++)
			alu(4'(i), 5'(i % 8 + 1), 5'(8 - i % 8), rf[i % 8 + 1], rf[8 - i % 8]);
		alu(`IEAMU_ALU_CLZ, 0, 0, 0, 0);
		alu(`IEAMU_ALU_CLO, 12, 0, rf[12], 0);
		rf_set = 7;
		alu(`IEAMU_ALU_ADD, 1, 0, 32'h5a5a0f0f, 0);
		rf_set = 0;
		rf_we = 1;
		rf_waddr = 14;
		rf_wdata = 32'h600dcafe;
		alu(`IEAMU_ALU_ADD, 14, 14, 32'h600dcafe, 32'h600dcafe);
		rf_we = 0;
		alu_valid = 0;
		agu_valid = 0;
		for (i = 1; i < 6; i++)
			md(`IEAMU_MD_MUL, 0, 5'(i), 5'(i + 1), 0, rf[i] * rf[i + 1]);
		for (a = 0; a < 4; a++) begin
			md(`IEAMU_MD_MULT, 2'(a), 5'(a + 1), 5'(a + 2), 0, 0);
			md(`IEAMU_MD_MADD, 2'(a), 5'(a + 3), 5'(a + 4), 0, 0);
		end
		req = 0;
		repeat (6) @(negedge clk);
		for (a = 0; a < 4; a++) begin
			hl_acc = 2'(a);
			e64 = $signed(rf[a + 1]) * $signed(rf[a + 2]) + $signed(rf[a + 3]) * $signed(rf[a + 4]);
			@(negedge clk);
			`CHK("acc", e64, {hl_hi_q, hl_lo_q})
		end
		hl_acc = 2;
		for (i = 0; i < 8; i++) begin
			wr(0, 9, dv[i]);
			rf_we = 0;
			e64 = i < 4 ? {rf[9] % 7, rf[9] / 7} : {$signed(rf[9]) % 7, $signed(rf[9]) / 7};
			md(i < 4 ? `IEAMU_MD_DIVU : `IEAMU_MD_DIV, 2, 9, 10, lt[i], e64);
			req = 0;
			repeat (40) @(negedge clk);
		end
		md(`IEAMU_MD_DIVU, 2, 9, 10, 36, {rf[9] % 7, rf[9] / 7});
		md_op = `IEAMU_MD_MUL;
		rude = 1;
		@(negedge clk);
		rude = 0;
		req = 0;
		alu(`IEAMU_ALU_SUB, 1, 2, rf[1], rf[2]);
		alu_valid = 0;
		agu_valid = 0;
		md(`IEAMU_MD_MUL, 0, 3, 4, 0, rf[3] * rf[4]);
		req = 0;
		repeat (12) @(negedge clk);
		end_sim;
	end
endmodule // tb
